/* File: hdl/radio_ctrl_consts.svh */
// Timing counts, reset values and readback codes of the radio state controller.
// Assumes every count except the keying symbol count is in crystal clock cycles, the clock of the controller itself.
`ifndef RADIO_CTRL_CONSTS_SVH
`define RADIO_CTRL_CONSTS_SVH

`define RC_GDO_DIV 192
`define RC_IDLE_RX_CYC 17'h007A1
`define RC_IDLE_TX_CYC 17'h007A2
`define RC_RX_TX_CYC 17'h0030E
`define RC_RX_IDLE_CYC 17'h00002
`define RC_MANCAL_CYC 17'h0011B
`define RC_FAST_CYC 17'h00001
`define RC_OOK_SYMBOLS 4'h8
`define RC_OOK_AMP_INDEX 3'h1
`define RC_RST_CYC 8'h40
`define RC_RB_CAL 5'h08

`endif

/* File: hdl/radio_ctrl_pkg.sv */
// Types shared by the radio state controller files.
// Assumes the constants header supplies all numeric values.
package radio_ctrl_pkg;

    typedef enum logic [3:0] {
        ST_SLEEP = 4'h0,
        ST_IDLE = 4'h1,
        ST_OSC_OFF_STATE = 4'h2,
        ST_WAIT = 4'h3,
        ST_RX = 4'h4,
        ST_TX = 4'h5,
        ST_FSON = 4'h6
    } state_t;

    typedef enum logic [1:0] {
        CAL_NEVER = 2'h0,
        CAL_ON_ENTRY = 2'h1,
        CAL_ON_RETURN = 2'h2,
        CAL_EVERY_FOURTH = 2'h3
    } autocal_t;

    typedef enum logic [1:0] {
        AFTER_IDLE = 2'h0,
        AFTER_FSON = 2'h1,
        AFTER_TX = 2'h2,
        AFTER_RX = 2'h3
    } after_tx_t;

    typedef enum logic [1:0] {
        CCA_ALWAYS = 2'h0,
        CCA_RSSI = 2'h1,
        CCA_NOT_RECEIVING = 2'h2,
        CCA_BOTH = 2'h3
    } cca_t;

endpackage : radio_ctrl_pkg

/* File: hdl/gdo_clock_divider.sv */
// Divides the crystal clock down for the default general output clock.
// Assumes a synchronous clear pulse from the reset strobe logic.
`timescale 1ns/1ps
`include "radio_ctrl_consts.svh"
module gdo_clock_divider (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clear_in,
    output logic div_clk_out
);
    localparam logic [7:0] HALF = 8'(`RC_GDO_DIV / 2);

    logic [7:0] cnt_ff;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_ff <= 8'h00;
            div_clk_out <= 1'b0;
        end else if (clear_in) begin
            cnt_ff <= 8'h00;
            div_clk_out <= 1'b0;
        end else if (cnt_ff == HALF - 8'h01) begin
            cnt_ff <= 8'h00;
            div_clk_out <= ~div_clk_out;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

endmodule : gdo_clock_divider

/* File: hdl/radio_state_controller.sv */
// Main radio control state machine: sleep, oscillator off, idle, receive, transmit,
// synthesizer on and calibration, with timed transitions in crystal cycles.
// Assumes same-clock one-cycle strobes and levels; chip select and oscillator-stable
// are asynchronous and synchronised here.
// How it works
// RL1: Strobes or internal events change the state.
// RL2: After any reset, output 0 is clock/192.
// RL3: After power-on reset: IDLE, oscillator on, ready low.
// RL4: Ready drives serial out while chip select low.
// RL5: Reset strobe restores defaults and enters IDLE.
// RL6: Host holds pins and pulses chip select first.
// RL7: Host waits ready, sends reset strobe, waits again.
// RL8: Ready goes low only after reset, in IDLE.
// RL9: Force-on keeps oscillator running in every state.
// RL10: Oscillator-off and power-down strobes act only from IDLE.
// RL11: Chip select fall wakes to IDLE, oscillator on.
// RL12: Regulator off in SLEEP, on at chip select low.
// RL13: Receive strobe enters RX, transmit strobe enters TX.
// RL14: Calibrate on strobe or per auto-calibration field.
// RL15: TX ends after packet, then after-transmit state.
// RL16: Receive strobe during TX switches to RX.
// RL17: Transmit or synth strobe in RX needs clear channel.
// RL18: Idle strobe forces IDLE from any state.
// RL19: Carrier abort leaves RX on first empty sample.
// RL20: On-off keying: absence valid after eight symbols.
// RL21: Fixed cycle counts for idle and switch transitions.
// RL22: RX to IDLE two cycles; manual calibration 283.
// RL23: TX to IDLE quarter bit, plus eighth with keying.
// RL24: Clear channel rule selects among four conditions.
// RL25: Timed transitions count cycles before target entry.
`timescale 1ns/1ps
`include "radio_ctrl_consts.svh"
module radio_state_controller
    import radio_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic chip_select_n_in,
    input wire logic osc_stable_in,
    input wire logic reset_strobe_in,
    input wire logic osc_off_strobe_in,
    input wire logic power_down_strobe_in,
    input wire logic receive_strobe_in,
    input wire logic transmit_strobe_in,
    input wire logic synth_on_strobe_in,
    input wire logic calibrate_strobe_in,
    input wire logic idle_strobe_in,
    input wire logic osc_force_on_in,
    input wire logic [1:0] auto_cal_select_in,
    input wire logic [1:0] after_tx_state_in,
    input wire logic [1:0] clear_channel_rule_in,
    input wire logic rx_carrier_abort_in,
    input wire logic [2:0] amp_level_index_in,
    input wire logic [15:0] quarter_bit_cycles_in,
    input wire logic [15:0] symbol_cycles_in,
    input wire logic [15:0] cal_time_cycles_in,
    input wire logic rssi_below_in,
    input wire logic receiving_packet_in,
    input wire logic carrier_sense_in,
    input wire logic carrier_sense_valid_in,
    input wire logic tx_packet_done_in,
    input wire logic tx_underflow_in,
    output logic [4:0] controller_state_readback_out,
    output logic general_output_0_out,
    output logic chip_ready_n_out,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    output logic osc_enable_out,
    output logic regulator_enable_out,
    output logic rx_active_out,
    output logic tx_active_out,
    output logic synth_cal_out,
    output logic soft_reset_out
);
    state_t state_ff, nxt_state, target_ff, nxt_target;
    logic [16:0] wait_len_ff, nxt_len, wait_cnt_ff;
    logic cal_flag_ff, nxt_cal, auto_ret;
    logic [1:0] cal_cnt_ff;
    logic [7:0] rst_cnt_ff;
    logic cs_meta_ff, cs_sync_ff, cs_prev_ff, stab_meta_ff, stab_sync_ff;
    logic [15:0] sym_cyc_ff;
    logic [3:0] sym_cnt_ff;
    logic cs_checked_ff;
    logic rst_busy, cs_fall, cca_ok, ook, absence_ok, abort_rx, sleepish;
    logic [16:0] quarter, tx_idle_len, cal_add, entry_cal, ret_cal;

    assign rst_busy = (rst_cnt_ff != 8'h00);
    assign cs_fall = cs_prev_ff & ~cs_sync_ff;
    assign ook = (amp_level_index_in == `RC_OOK_AMP_INDEX); // RL23
    assign quarter = {1'b0, quarter_bit_cycles_in};
    assign tx_idle_len = quarter + (ook ? (quarter >> 1) : 17'h00000); // RL23
    assign cal_add = {1'b0, cal_time_cycles_in};
    assign entry_cal = (autocal_t'(auto_cal_select_in) == CAL_ON_ENTRY) ? cal_add : 17'h00000;
    assign ret_cal = ((autocal_t'(auto_cal_select_in) == CAL_ON_RETURN) ||
                      ((autocal_t'(auto_cal_select_in) == CAL_EVERY_FOURTH) &&
                       (cal_cnt_ff == 2'h3))) ? cal_add : 17'h00000; // RL14
    assign absence_ok = ~ook || (sym_cnt_ff == `RC_OOK_SYMBOLS); // RL20
    assign abort_rx = (state_ff == ST_RX) && rx_carrier_abort_in && ~cs_checked_ff &&
                      carrier_sense_valid_in && ~carrier_sense_in && absence_ok; // RL19
    assign sleepish = (state_ff == ST_SLEEP) || (state_ff == ST_OSC_OFF_STATE);

    always_comb begin
        case (cca_t'(clear_channel_rule_in)) // RL24
            CCA_ALWAYS: cca_ok = 1'b1;
            CCA_RSSI: cca_ok = rssi_below_in;
            CCA_NOT_RECEIVING: cca_ok = ~receiving_packet_in;
            default: cca_ok = rssi_below_in & ~receiving_packet_in;
        endcase
    end

    // Both asynchronous inputs pass two flip-flops before any logic sees them.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
            stab_meta_ff <= 1'b0;
            stab_sync_ff <= 1'b0;
        end else begin
            cs_meta_ff <= chip_select_n_in;
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
            stab_meta_ff <= osc_stable_in;
            stab_sync_ff <= stab_meta_ff;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_target = target_ff;
        nxt_len = wait_len_ff;
        nxt_cal = cal_flag_ff;
        auto_ret = 1'b0;
        if (reset_strobe_in || rst_busy) begin
            nxt_state = ST_IDLE; // RL5
            nxt_cal = 1'b0;
        end else if (idle_strobe_in) begin
            nxt_state = ST_IDLE; // RL18
            nxt_cal = 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (receive_strobe_in) begin
                        nxt_state = ST_WAIT; // RL13
                        nxt_target = ST_RX;
                        nxt_len = `RC_IDLE_RX_CYC + entry_cal; // RL21
                        nxt_cal = (entry_cal != 17'h00000); // RL14
                    end else if (transmit_strobe_in || synth_on_strobe_in) begin
                        nxt_state = ST_WAIT; // RL13
                        nxt_target = transmit_strobe_in ? ST_TX : ST_FSON;
                        nxt_len = `RC_IDLE_TX_CYC + entry_cal; // RL21
                        nxt_cal = (entry_cal != 17'h00000);
                    end else if (calibrate_strobe_in) begin
                        nxt_state = ST_WAIT; // RL14
                        nxt_target = ST_IDLE;
                        nxt_len = `RC_MANCAL_CYC + cal_add; // RL22
                        nxt_cal = 1'b1;
                    end else if (osc_off_strobe_in) begin
                        nxt_state = ST_OSC_OFF_STATE; // RL10
                    end else if (power_down_strobe_in) begin
                        nxt_state = ST_SLEEP; // RL10
                    end
                end
                ST_SLEEP, ST_OSC_OFF_STATE: begin
                    if (cs_fall) begin
                        nxt_state = ST_IDLE; // RL11
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt_ff + 17'h00001 >= wait_len_ff) begin
                        nxt_state = target_ff; // RL25
                        nxt_cal = 1'b0;
                    end
                end
                ST_RX: begin
                    if ((transmit_strobe_in || synth_on_strobe_in) && cca_ok) begin
                        nxt_state = ST_WAIT; // RL17
                        nxt_target = transmit_strobe_in ? ST_TX : ST_FSON;
                        nxt_len = `RC_RX_TX_CYC; // RL21
                        nxt_cal = 1'b0;
                    end else if (abort_rx) begin
                        nxt_state = ST_WAIT; // RL19
                        nxt_target = ST_IDLE;
                        nxt_len = `RC_RX_IDLE_CYC + ret_cal; // RL22
                        nxt_cal = (ret_cal != 17'h00000);
                        auto_ret = 1'b1;
                    end
                end
                ST_TX: begin
                    nxt_cal = 1'b0;
                    if (receive_strobe_in) begin
                        nxt_state = ST_WAIT; // RL16
                        nxt_target = ST_RX;
                        nxt_len = `RC_RX_TX_CYC + quarter; // RL21
                    end else if (tx_underflow_in) begin
                        nxt_state = ST_WAIT; // RL1
                        nxt_target = ST_IDLE;
                        nxt_len = tx_idle_len;
                    end else if (tx_packet_done_in) begin
                        nxt_state = ST_WAIT; // RL15
                        case (after_tx_t'(after_tx_state_in))
                            AFTER_IDLE: begin
                                nxt_target = ST_IDLE;
                                nxt_len = tx_idle_len + ret_cal; // RL23
                                nxt_cal = (ret_cal != 17'h00000);
                                auto_ret = 1'b1;
                            end
                            AFTER_FSON: begin
                                nxt_target = ST_FSON;
                                nxt_len = quarter;
                            end
                            AFTER_TX: begin
                                nxt_target = ST_TX;
                                nxt_len = `RC_FAST_CYC;
                            end
                            default: begin
                                nxt_target = ST_RX;
                                nxt_len = `RC_RX_TX_CYC + quarter;
                            end
                        endcase
                    end
                end
                ST_FSON: begin
                    if (transmit_strobe_in || receive_strobe_in) begin
                        nxt_state = ST_WAIT;
                        nxt_target = transmit_strobe_in ? ST_TX : ST_RX;
                        nxt_len = `RC_RX_TX_CYC;
                        nxt_cal = 1'b0;
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= ST_IDLE; // RL3
            target_ff <= ST_IDLE;
            wait_len_ff <= 17'h00000;
            cal_flag_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state; // RL1
            target_ff <= nxt_target;
            wait_len_ff <= nxt_len;
            cal_flag_ff <= nxt_cal;
        end
    end

    // The counter restarts on every entry into a timed transition.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wait_cnt_ff <= 17'h00000;
        end else if (state_ff != ST_WAIT || nxt_state != ST_WAIT) begin
            wait_cnt_ff <= 17'h00000;
        end else begin
            wait_cnt_ff <= wait_cnt_ff + 17'h00001; // RL25
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cal_cnt_ff <= 2'h0;
        end else if (reset_strobe_in) begin
            cal_cnt_ff <= 2'h0;
        end else if (auto_ret) begin
            cal_cnt_ff <= cal_cnt_ff + 2'h1; // RL14
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rst_cnt_ff <= 8'h00;
        end else if (reset_strobe_in) begin
            rst_cnt_ff <= `RC_RST_CYC; // RL5
        end else if (rst_busy) begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
        end
    end

    // Symbol periods spent in receive, and whether a valid sense sample showing carrier, or empty once absence is valid, was seen.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sym_cyc_ff <= 16'h0000;
            sym_cnt_ff <= 4'h0;
            cs_checked_ff <= 1'b0;
        end else if (state_ff != ST_RX) begin
            sym_cyc_ff <= 16'h0000;
            sym_cnt_ff <= 4'h0;
            cs_checked_ff <= 1'b0;
        end else begin
            if (sym_cnt_ff != `RC_OOK_SYMBOLS) begin
                if (sym_cyc_ff + 16'h0001 >= symbol_cycles_in) begin
                    sym_cyc_ff <= 16'h0000;
                    sym_cnt_ff <= sym_cnt_ff + 4'h1; // RL20
                end else begin
                    sym_cyc_ff <= sym_cyc_ff + 16'h0001;
                end
            end
            if (carrier_sense_valid_in && (carrier_sense_in || absence_ok)) begin
                cs_checked_ff <= 1'b1; // RL19
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            controller_state_readback_out <= 5'h01;
            chip_ready_n_out <= 1'b1;
            serial_data_out <= 1'b1;
            serial_data_oe_out <= 1'b0;
            osc_enable_out <= 1'b1;
            regulator_enable_out <= 1'b1;
            rx_active_out <= 1'b0;
            tx_active_out <= 1'b0;
            synth_cal_out <= 1'b0;
            soft_reset_out <= 1'b0;
        end else begin
            controller_state_readback_out <= (state_ff == ST_WAIT && cal_flag_ff) ?
                                             `RC_RB_CAL : {1'b0, state_ff};
            chip_ready_n_out <= ~(stab_sync_ff && ~rst_busy && ~reset_strobe_in &&
                                  ~sleepish); // RL3 RL8
            serial_data_out <= ~(stab_sync_ff && ~rst_busy && ~reset_strobe_in && ~sleepish);
            serial_data_oe_out <= ~cs_sync_ff; // RL4
            osc_enable_out <= osc_force_on_in || ~(sleepish && cs_sync_ff); // RL9 RL10
            regulator_enable_out <= ~(state_ff == ST_SLEEP && cs_sync_ff); // RL12
            rx_active_out <= (state_ff == ST_RX);
            tx_active_out <= (state_ff == ST_TX);
            synth_cal_out <= (state_ff == ST_WAIT) && cal_flag_ff; // RL14
            soft_reset_out <= reset_strobe_in;
        end
    end

    gdo_clock_divider u_gdo_div (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .clear_in(reset_strobe_in),
        .div_clk_out(general_output_0_out) // RL2
    );

    property p_idle_forced;
        @(posedge clk_in) disable iff (reset_in)
        idle_strobe_in |=> state_ff == ST_IDLE;
    endproperty
    a_idle_forced: assert property (p_idle_forced) else $error("idle strobe ignored"); // RL18

    property p_rx_entry;
        @(posedge clk_in) disable iff (reset_in)
        (state_ff == ST_IDLE && receive_strobe_in && !idle_strobe_in && !reset_strobe_in &&
         !rst_busy) |=> (state_ff == ST_WAIT && target_ff == ST_RX);
    endproperty
    a_rx_entry: assert property (p_rx_entry) else $error("receive strobe not taken"); // RL13

    property p_cca_block;
        @(posedge clk_in) disable iff (reset_in)
        (state_ff == ST_RX && transmit_strobe_in && !cca_ok && !abort_rx && !idle_strobe_in &&
         !reset_strobe_in && !rst_busy) |=> state_ff == ST_RX;
    endproperty
    a_cca_block: assert property (p_cca_block) else $error("busy channel left RX"); // RL17

    property p_tx_to_rx;
        @(posedge clk_in) disable iff (reset_in)
        (state_ff == ST_TX && receive_strobe_in && !idle_strobe_in && !reset_strobe_in &&
         !rst_busy) |=> (target_ff == ST_RX && wait_len_ff == `RC_RX_TX_CYC + $past(quarter));
    endproperty
    a_tx_to_rx: assert property (p_tx_to_rx) else $error("TX to RX switch wrong"); // RL16

    property p_sleep_regulator;
        @(posedge clk_in) disable iff (reset_in)
        (state_ff == ST_SLEEP && cs_sync_ff) |=> !regulator_enable_out;
    endproperty
    a_sleep_regulator: assert property (p_sleep_regulator) else $error("regulator on"); // RL12

    property p_force_on;
        @(posedge clk_in) disable iff (reset_in)
        osc_force_on_in |=> osc_enable_out;
    endproperty
    a_force_on: assert property (p_force_on) else $error("forced oscillator stopped"); // RL9

    property p_gdo_period;
        @(posedge clk_in) disable iff (reset_in || reset_strobe_in)
        $rose(general_output_0_out) |-> ##96 $fell(general_output_0_out);
    endproperty
    a_gdo_period: assert property (p_gdo_period) else $error("output 0 period wrong"); // RL2

    property p_wait_holds;
        @(posedge clk_in) disable iff (reset_in)
        (state_ff == ST_WAIT && wait_cnt_ff + 17'h00001 < wait_len_ff && !idle_strobe_in &&
         !reset_strobe_in && !rst_busy) |=> state_ff == ST_WAIT;
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("transition ended early"); // RL25

    property p_reset_ready;
        @(posedge clk_in) disable iff (reset_in)
        reset_strobe_in |=> chip_ready_n_out [*8];
    endproperty
    a_reset_ready: assert property (p_reset_ready) else $error("ready during reset"); // RL8

endmodule : radio_state_controller

/* File: verification/host_strobe_model.sv */
// Host model that drives chip select and one-cycle command strobes.
// Assumes the controller's clock; every change lands just after a rising edge.
`timescale 1ns/1ps
module host_strobe_model (
    input wire logic clk_in,
    output logic chip_select_n_out,
    output logic [7:0] strobes_out
);
    initial begin
        chip_select_n_out = 1'b1;
        strobes_out = 8'h00;
    end
    // Bits: 0 reset, 1 osc off, 2 power down, 3 receive, 4 transmit, 5 synth, 6 cal, 7 idle.
    task automatic strobe(input int idx);
        @(posedge clk_in);
        strobes_out[idx] <= 1'b1;
        @(posedge clk_in);
        strobes_out <= 8'h00;
    endtask : strobe
    task automatic select(input logic level);
        @(posedge clk_in);
        chip_select_n_out <= level;
    endtask : select
endmodule : host_strobe_model

/* File: verification/radio_state_controller_bench.sv */
// Self-checking bench for the radio state controller, driven through a host strobe model.
// Assumes the controller's readback codes and transition counts.
`timescale 1ns/1ps
`include "radio_ctrl_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module radio_state_controller_bench import radio_ctrl_pkg::*; ;
    logic clk_in, reset_in, osc_stable_in, osc_force_on_in, rx_carrier_abort_in;
    logic rssi_below_in, receiving_packet_in, carrier_sense_in, carrier_sense_valid_in;
    logic tx_packet_done_in, tx_underflow_in, chip_select_n, general_output_0_out;
    logic [1:0] auto_cal_select_in, after_tx_state_in, clear_channel_rule_in;
    logic [2:0] amp_level_index_in;
    logic [15:0] quarter_bit_cycles_in, symbol_cycles_in, cal_time_cycles_in;
    logic [4:0] controller_state_readback_out;
    logic [7:0] stb;
    logic chip_ready_n_out, serial_data_out, serial_data_oe_out, osc_enable_out;
    logic regulator_enable_out, rx_active_out, tx_active_out, synth_cal_out, soft_reset_out;
    logic [31:0] seed = 32'h0000E448;
    int failures = 0;
    int checks_done = 0;
    int n, cal, dst, qb;
    logic [4:0] tgt [4] = '{5'h01, 5'h06, 5'h05, 5'h04};
    wire [4:0] rb = controller_state_readback_out;
    radio_state_controller dut (.clk_in, .reset_in, .chip_select_n_in(chip_select_n),
        .osc_stable_in, .reset_strobe_in(stb[0]), .osc_off_strobe_in(stb[1]),
        .power_down_strobe_in(stb[2]), .receive_strobe_in(stb[3]),
        .transmit_strobe_in(stb[4]), .synth_on_strobe_in(stb[5]),
        .calibrate_strobe_in(stb[6]), .idle_strobe_in(stb[7]), .osc_force_on_in,
        .auto_cal_select_in, .after_tx_state_in, .clear_channel_rule_in, .rx_carrier_abort_in,
        .amp_level_index_in, .quarter_bit_cycles_in, .symbol_cycles_in, .cal_time_cycles_in,
        .rssi_below_in, .receiving_packet_in, .carrier_sense_in, .carrier_sense_valid_in,
        .tx_packet_done_in, .tx_underflow_in, .controller_state_readback_out,
        .general_output_0_out, .chip_ready_n_out, .serial_data_out, .serial_data_oe_out,
        .osc_enable_out, .regulator_enable_out, .rx_active_out, .tx_active_out,
        .synth_cal_out, .soft_reset_out);
    host_strobe_model host (.clk_in, .chip_select_n_out(chip_select_n), .strobes_out(stb));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    function automatic logic channel_clear(input logic [1:0] rule, input logic below,
        input logic busy);
        case (rule)
            CCA_ALWAYS: return 1'b1;
            CCA_RSSI: return below;
            CCA_NOT_RECEIVING: return !busy;
            default: return below && !busy;
        endcase
    endfunction : channel_clear
    task automatic print_verdict;
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : tick
    // Counts cycles until the readback shows the code; a spent bound fails.
    task automatic wait_rb(input logic [4:0] code, input int limit, output int cnt);
        cnt = 0;
        while (rb !== code) begin
            tick(1);
            cnt++;
            if (cnt > limit) begin
                failures++;
                print_verdict();
            end
        end
    endtask : wait_rb
    task automatic pulse_event(input bit underflow);
        @(posedge clk_in);
        if (underflow) tx_underflow_in <= 1'b1;
        else tx_packet_done_in <= 1'b1;
        @(posedge clk_in);
        tx_underflow_in <= 1'b0;
        tx_packet_done_in <= 1'b0;
    endtask : pulse_event
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        #(20 * 100000);
        failures++;
        print_verdict();
    end
    initial begin
        {reset_in, osc_stable_in, osc_force_on_in, rx_carrier_abort_in} = 4'h8;
        {rssi_below_in, receiving_packet_in, carrier_sense_in, carrier_sense_valid_in} = 4'h0;
        {tx_packet_done_in, tx_underflow_in, auto_cal_select_in, after_tx_state_in} = 6'h00;
        {clear_channel_rule_in, amp_level_index_in} = 5'h00;
        quarter_bit_cycles_in = 16'h0010;
        symbol_cycles_in = 16'h0004;
        cal_time_cycles_in = 16'h0010;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        tick(2);
        `CHK(rb, 5'h01)
        `CHK(osc_enable_out, 1'b1)
        host.select(1'b0);
        tick(4);
        `CHK(serial_data_oe_out, 1'b1)
        `CHK(serial_data_out, 1'b1)
        osc_stable_in <= 1'b1;
        tick(5);
        `CHK(serial_data_out, 1'b0)
        `CHK(chip_ready_n_out, 1'b0)
        n = 0;
        while (general_output_0_out !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        n = 0;
        while (general_output_0_out === 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        `CHK(n, `RC_GDO_DIV / 2)
        for (int i = 0; i < 6; i++) begin
            seed = xorshift(seed);
            {after_tx_state_in, carrier_sense_in, osc_force_on_in, rx_carrier_abort_in,
             receiving_packet_in, rssi_below_in, clear_channel_rule_in} <= seed[8:0];
            {auto_cal_select_in[0], quarter_bit_cycles_in[3:0], symbol_cycles_in[3:0],
             cal_time_cycles_in[3:0]} <= seed[21:9];
            host.strobe(3);
            cal = auto_cal_select_in[0] ? cal_time_cycles_in : 0;
            wait_rb(cal ? 5'h08 : 5'h03, 10, n);
            wait_rb(5'h04, 2100, n);
            `CHK(n, 1953 + cal)
            `CHK(rx_active_out, 1'b1)
            host.strobe(i[0] ? 4 : 5);
            if (channel_clear(seed[1:0], seed[2], seed[3])) begin
                wait_rb(5'h03, 10, n);
                wait_rb(i[0] ? 5'h05 : 5'h06, 900, n);
                `CHK(n, 782)
            end else begin
                tick(6);
                `CHK(rb, 5'h04)
            end
            host.strobe(7);
            tick(3);
            `CHK(rb, 5'h01)
        end
        for (int j = 0; j < 3; j++) begin
            amp_level_index_in <= (j == 1) ? `RC_OOK_AMP_INDEX : 3'h0;
            host.strobe(4);
            wait_rb(cal ? 5'h08 : 5'h03, 10, n);
            wait_rb(5'h05, 2100, n);
            `CHK(n, 1954 + cal)
            `CHK(tx_active_out, 1'b1)
            if (j == 2) host.strobe(3);
            else pulse_event(j == 1);
            dst = (j == 2) ? 3 : (j == 1 ? 0 : after_tx_state_in);
            qb = quarter_bit_cycles_in;
            wait_rb(5'h03, 10, n);
            wait_rb(tgt[dst], 900, n);
            `CHK(n, dst == 3 ? 782 + qb : (dst == 2 ? 1 : qb + (j == 1) * qb / 2))
            if (j == 0) host.strobe(7);
        end
        {rx_carrier_abort_in, carrier_sense_in} <= 2'h2;
        @(posedge clk_in);
        carrier_sense_valid_in <= 1'b1;
        @(posedge clk_in);
        carrier_sense_valid_in <= 1'b0;
        wait_rb(5'h03, 10, n);
        wait_rb(5'h01, 20, n);
        `CHK(n, 2)
        host.strobe(6);
        wait_rb(5'h08, 10, n);
        `CHK(synth_cal_out, 1'b1)
        wait_rb(5'h01, 400, n);
        `CHK(n, 283 + cal_time_cycles_in)
        host.strobe(1);
        host.select(1'b1);
        tick(6);
        `CHK(rb, 5'h02)
        `CHK(osc_enable_out, osc_force_on_in)
        host.select(1'b0);
        tick(6);
        `CHK(rb, 5'h01)
        host.strobe(2);
        host.select(1'b1);
        tick(6);
        `CHK(regulator_enable_out, 1'b0)
        host.select(1'b0);
        tick(6);
        `CHK(regulator_enable_out, 1'b1)
        host.strobe(0);
        tick(0);
        `CHK(soft_reset_out, 1'b1)
        `CHK(chip_ready_n_out, 1'b1)
        tick(70);
        `CHK(chip_ready_n_out, 1'b0)
        print_verdict();
    end
endmodule : radio_state_controller_bench
